// ===== tcr_defines.svh
// tcr_defines.svh: register offsets, field positions, reset values, fixed tops and prescaler taps of the 16-bit timer
// assumes: included by every design file of the timer except the package; definitions only
`ifndef TCR_DEFINES_SVH
`define TCR_DEFINES_SVH

// byte offsets on the plain register port
`define TCR_OFS_CTRL_A 8'h00
`define TCR_OFS_CTRL_B 8'h01
`define TCR_OFS_CTRL_C 8'h02
`define TCR_OFS_CNT_L 8'h04
`define TCR_OFS_CNT_H 8'h05
`define TCR_OFS_CAP_L 8'h06
`define TCR_OFS_CAP_H 8'h07
`define TCR_OFS_CMPA_L 8'h08
`define TCR_OFS_CMPA_H 8'h09
`define TCR_OFS_CMPB_L 8'h0A
`define TCR_OFS_CMPB_H 8'h0B
`define TCR_OFS_IEN 8'h0C
`define TCR_OFS_IFLG 8'h0D

// control b fields
`define TCR_B_FILT 7
`define TCR_B_EDGE 6
`define TCR_B_RSVD 5
`define TCR_B_WGM_HI 4
`define TCR_B_WGM_LO 3
// control c fields
`define TCR_C_FORCE_A 7
`define TCR_C_FORCE_B 6
// interrupt enable and flag positions
`define TCR_I_CAP 5
`define TCR_I_CMPB 2
`define TCR_I_CMPA 1
`define TCR_I_OVF 0
`define TCR_I_MASK 8'h27

// reset values
`define TCR_RST_BYTE 8'h00
`define TCR_RST_WORD 16'h0000

// fixed tops
`define TCR_TOP_16 16'hFFFF
`define TCR_TOP_8 16'h00FF
`define TCR_TOP_9 16'h01FF
`define TCR_TOP_10 16'h03FF

// prescaler taps, as terminal values of a 10-bit divider
`define TCR_DIV_8 10'h007
`define TCR_DIV_64 10'h03F
`define TCR_DIV_256 10'h0FF
`define TCR_DIV_1024 10'h3FF

// input filter length in samples
`define TCR_FILT_LEN 3'h4

`endif

// ===== tcr_pkg.sv
// tcr_pkg.sv: types of the 16-bit timer
// assumes: nothing beyond the defines header
package tcr_pkg;
	typedef enum logic [2:0] {
		TCR_CS_STOP = 3'h0,
		TCR_CS_DIV1 = 3'h1,
		TCR_CS_DIV8 = 3'h2,
		TCR_CS_DIV64 = 3'h3,
		TCR_CS_DIV256 = 3'h4,
		TCR_CS_DIV1024 = 3'h5,
		TCR_CS_EXT_FALL = 3'h6,
		TCR_CS_EXT_RISE = 3'h7
	} tcr_clksel_t;

	// counter direction state, gray along up -> down
	typedef enum logic [0:0] {
		TCR_DIR_UP = 1'b0,
		TCR_DIR_DOWN = 1'b1
	} tcr_dir_t;
endpackage

// ===== tcr_filter.sv
// tcr_filter.sv: optional four-sample glitch filter for one input line
// assumes: input already synchronous to clk_sys_i
`timescale 1ns/100ps
`include "tcr_defines.svh"

module tcr_filter (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// control
	input wire logic enable_i,
	// data
	input wire logic raw_i,
	output logic filt_o
);
	import tcr_pkg::*;

	logic [2:0] same_reg;
	logic [2:0] same_next;
	logic held_reg;
	logic held_next;
	wire logic differs = raw_i != held_reg;
	wire logic settle = differs && (same_reg == `TCR_FILT_LEN - 3'h1);

	// output changes only once four samples in a row disagree with it
	assign same_next = !differs ? 3'h0 : (settle ? 3'h0 : same_reg + 3'h1);
	assign held_next = (!enable_i || settle) ? raw_i : held_reg;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			same_reg <= 3'h0;
			held_reg <= 1'b0;
		end else begin
			same_reg <= same_next;
			held_reg <= held_next;
		end
	end

	assign filt_o = held_reg;
endmodule

// ===== tcr_timer16.sv
// tcr_timer16.sv: 16-bit timer/counter with two compare channels, one capture channel and byte-wide registers
// assumes: pins and register strobes synchronous to clk_sys_i; read data valid the cycle after a read strobe
`timescale 1ns/100ps
`include "tcr_defines.svh"

module tcr_timer16 (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// pins and system
	input wire logic capture_input_pin_i,
	input wire logic comparator_out_i,
	input wire logic capture_from_comparator_i,
	input wire logic external_count_pin_i,
	input wire logic global_irq_enable_i,
	input wire logic [3:0] irq_ack_i,
	// outputs
	output logic wave_out_a_o,
	output logic wave_out_b_o,
	output logic [3:0] irq_o
);
	import tcr_pkg::*;

	logic [7:0] ctrl_a_reg;
	logic [7:0] ctrl_b_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [15:0] cmpa_reg;
	logic [15:0] cmpb_reg;
	logic [15:0] cap_reg;
	logic [7:0] temp_reg;
	logic [7:0] ien_reg;
	logic [7:0] flg_reg;
	logic [7:0] flg_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [9:0] pre_reg;
	logic ext_d_reg;
	logic cap_d_reg;
	logic dir_reg;
	logic dir_next;
	logic block_reg;
	logic mat_a_reg;
	logic mat_b_reg;
	logic wave_a_reg;
	logic wave_b_reg;
	logic [3:0] irq_reg;

	// field decode
	wire logic [3:0] wgm = {ctrl_b_reg[`TCR_B_WGM_HI:`TCR_B_WGM_LO], ctrl_a_reg[1:0]};
	wire logic [1:0] mode_a = ctrl_a_reg[7:6];
	wire logic [1:0] mode_b = ctrl_a_reg[5:4];
	wire tcr_clksel_t csel = tcr_clksel_t'(ctrl_b_reg[2:0]);

	// waveform mode classes
	wire logic m_normal = wgm == 4'h0;
	wire logic m_ctc_a = wgm == 4'h4;
	wire logic m_ctc_cap = wgm == 4'hC;
	wire logic m_non_pwm = m_normal || m_ctc_a || m_ctc_cap;
	wire logic m_fast = (wgm == 4'h5) || (wgm == 4'h6) || (wgm == 4'h7) || (wgm == 4'hE) || (wgm == 4'hF);
	wire logic m_dual = !m_non_pwm && !m_fast && (wgm != 4'hD);
	wire logic top_is_cap = (wgm == 4'h8) || (wgm == 4'hA) || m_ctc_cap || (wgm == 4'hE);
	wire logic top_is_a = (wgm == 4'h9) || (wgm == 4'hB) || m_ctc_a || (wgm == 4'hF);
	wire logic [1:0] res_sel = wgm[1:0];
	// reserved mode 13 runs as a plain up count to the 10-bit top
	wire logic [15:0] fixed_top = (wgm == 4'hD) ? `TCR_TOP_10 : (res_sel == 2'h1) ? `TCR_TOP_8 :
		(res_sel == 2'h2) ? `TCR_TOP_9 : `TCR_TOP_10;
	wire logic [15:0] top_val = m_normal ? `TCR_TOP_16 : top_is_cap ? cap_reg : top_is_a ? cmpa_reg : fixed_top;

	// register port decode
	wire logic wr_ctrl_a = reg_wr_i && (reg_addr_i == `TCR_OFS_CTRL_A);
	wire logic wr_ctrl_b = reg_wr_i && (reg_addr_i == `TCR_OFS_CTRL_B);
	wire logic wr_ctrl_c = reg_wr_i && (reg_addr_i == `TCR_OFS_CTRL_C);
	wire logic wr_cnt_l = reg_wr_i && (reg_addr_i == `TCR_OFS_CNT_L);
	wire logic wr_cap_l = reg_wr_i && (reg_addr_i == `TCR_OFS_CAP_L);
	wire logic wr_cmpa_l = reg_wr_i && (reg_addr_i == `TCR_OFS_CMPA_L);
	wire logic wr_cmpb_l = reg_wr_i && (reg_addr_i == `TCR_OFS_CMPB_L);
	wire logic wr_ien = reg_wr_i && (reg_addr_i == `TCR_OFS_IEN);
	wire logic wr_flg = reg_wr_i && (reg_addr_i == `TCR_OFS_IFLG);
	// any high-byte write lands in the shared latch
	wire logic wr_high = reg_wr_i && ((reg_addr_i == `TCR_OFS_CNT_H) || (reg_addr_i == `TCR_OFS_CAP_H) ||
		(reg_addr_i == `TCR_OFS_CMPA_H) || (reg_addr_i == `TCR_OFS_CMPB_H));
	wire logic rd_cnt_l = reg_rd_i && (reg_addr_i == `TCR_OFS_CNT_L);
	wire logic rd_cap_l = reg_rd_i && (reg_addr_i == `TCR_OFS_CAP_L);
	wire logic [15:0] wr_word = {temp_reg, reg_wdata_i};

	// force strobes only act in non-pwm modes
	wire logic force_a = wr_ctrl_c && reg_wdata_i[`TCR_C_FORCE_A] && m_non_pwm;
	wire logic force_b = wr_ctrl_c && reg_wdata_i[`TCR_C_FORCE_B] && m_non_pwm;

	// prescaler and clock select
	wire logic ext_rise = external_count_pin_i && !ext_d_reg;
	wire logic ext_fall = !external_count_pin_i && ext_d_reg;
	logic tick;
	always_comb begin
		case (csel)
			TCR_CS_STOP: tick = 1'b0;
			TCR_CS_DIV1: tick = 1'b1;
			TCR_CS_DIV8: tick = (pre_reg & `TCR_DIV_8) == `TCR_DIV_8;
			TCR_CS_DIV64: tick = (pre_reg & `TCR_DIV_64) == `TCR_DIV_64;
			TCR_CS_DIV256: tick = (pre_reg & `TCR_DIV_256) == `TCR_DIV_256;
			TCR_CS_DIV1024: tick = pre_reg == `TCR_DIV_1024;
			// pin level is sampled whatever drives it, so software can clock the count
			TCR_CS_EXT_FALL: tick = ext_fall;
			TCR_CS_EXT_RISE: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end

	// counter sequencing
	wire logic at_top = cnt_reg == top_val;
	wire logic at_bot = cnt_reg == `TCR_RST_WORD;
	always_comb begin
		cnt_next = cnt_reg;
		dir_next = dir_reg;
		if (wr_cnt_l) begin
			// cpu write wins over counting
			cnt_next = wr_word;
		end else if (tick) begin
			if (m_dual) begin
				if (dir_reg == TCR_DIR_UP) begin
					if (at_top) begin
						dir_next = TCR_DIR_DOWN;
						cnt_next = cnt_reg - 16'h0001;
					end else begin
						cnt_next = cnt_reg + 16'h0001;
					end
				end else if (at_bot) begin
					dir_next = TCR_DIR_UP;
					cnt_next = cnt_reg + 16'h0001;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end else if (at_top && !m_normal) begin
				// ctc and fast pwm wrap at top; forced matches never reach here
				cnt_next = `TCR_RST_WORD;
			end else begin
				cnt_next = cnt_reg + 16'h0001;
			end
		end
	end

	// compare: equality seen on one tick, flagged on the next
	wire logic eq_a = (cnt_reg == cmpa_reg) && !block_reg;
	wire logic eq_b = (cnt_reg == cmpb_reg) && !block_reg;
	wire logic set_a = tick && mat_a_reg;
	wire logic set_b = tick && mat_b_reg;

	// capture source and edge
	logic cap_filt;
	wire logic cap_src = capture_from_comparator_i ? comparator_out_i : capture_input_pin_i;
	tcr_filter u_filter (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.enable_i(ctrl_b_reg[`TCR_B_FILT]),
		.raw_i(cap_src),
		.filt_o(cap_filt)
	);
	wire logic cap_edge = ctrl_b_reg[`TCR_B_EDGE] ? (cap_filt && !cap_d_reg) : (!cap_filt && cap_d_reg);
	wire logic cap_event = cap_edge && !top_is_cap;
	// capture-top modes flag the capture bit at top instead
	wire logic cap_top = tick && top_is_cap && at_top && (dir_reg == TCR_DIR_UP);

	// overflow point per mode
	wire logic ovf_set = tick && ((m_non_pwm && (cnt_reg == `TCR_TOP_16)) || (m_fast && at_top) ||
		(m_dual && at_bot && (dir_reg == TCR_DIR_DOWN)));

	// flags: hardware set wins over write-one clear and vector ack
	wire logic [7:0] flg_set = {2'b00, cap_event || cap_top, 2'b00, set_b, set_a, ovf_set};
	wire logic [7:0] flg_clr = (wr_flg ? reg_wdata_i : 8'h00) |
		{2'b00, irq_ack_i[3], 2'b00, irq_ack_i[2], irq_ack_i[1], irq_ack_i[0]};
	assign flg_next = ((flg_reg & ~flg_clr) | flg_set) & `TCR_I_MASK;

	// interrupt requests gated by enables and global enable
	wire logic [7:0] pend = flg_next & ien_reg;
	wire logic [3:0] irq_next = global_irq_enable_i ?
		{pend[`TCR_I_CAP], pend[`TCR_I_CMPB], pend[`TCR_I_CMPA], pend[`TCR_I_OVF]} : 4'h0;

	// waveform output on a match, real or forced, in non-pwm modes
	function automatic logic wave_step(input logic cur, input logic [1:0] md);
		case (md)
			2'h1: wave_step = !cur;
			2'h2: wave_step = 1'b0;
			2'h3: wave_step = 1'b1;
			default: wave_step = cur;
		endcase
	endfunction
	wire logic hit_a = force_a || (tick && mat_a_reg && m_non_pwm);
	wire logic hit_b = force_b || (tick && mat_b_reg && m_non_pwm);
	wire logic wave_a_next = hit_a ? wave_step(wave_a_reg, mode_a) : wave_a_reg;
	wire logic wave_b_next = hit_b ? wave_step(wave_b_reg, mode_b) : wave_b_reg;

	// read mux; count and capture high bytes come from the latch filled by the low-byte read
	always_comb begin
		case (reg_addr_i)
			`TCR_OFS_CTRL_A: rdata_next = ctrl_a_reg;
			`TCR_OFS_CTRL_B: rdata_next = ctrl_b_reg;
			`TCR_OFS_CTRL_C: rdata_next = 8'h00;
			`TCR_OFS_CNT_L: rdata_next = cnt_reg[7:0];
			`TCR_OFS_CAP_L: rdata_next = cap_reg[7:0];
			`TCR_OFS_CMPA_L: rdata_next = cmpa_reg[7:0];
			`TCR_OFS_CMPA_H: rdata_next = cmpa_reg[15:8];
			`TCR_OFS_CMPB_L: rdata_next = cmpb_reg[7:0];
			`TCR_OFS_CMPB_H: rdata_next = cmpb_reg[15:8];
			`TCR_OFS_CNT_H: rdata_next = temp_reg;
			`TCR_OFS_CAP_H: rdata_next = temp_reg;
			`TCR_OFS_IEN: rdata_next = ien_reg;
			`TCR_OFS_IFLG: rdata_next = flg_reg;
			default: rdata_next = 8'h00;
		endcase
	end
	wire logic [7:0] temp_next = wr_high ? reg_wdata_i : rd_cnt_l ? cnt_reg[15:8] :
		rd_cap_l ? cap_reg[15:8] : temp_reg;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ctrl_a_reg <= `TCR_RST_BYTE;
			ctrl_b_reg <= `TCR_RST_BYTE;
			ien_reg <= `TCR_RST_BYTE;
			temp_reg <= `TCR_RST_BYTE;
			rdata_reg <= `TCR_RST_BYTE;
		end else begin
			if (wr_ctrl_a) ctrl_a_reg <= reg_wdata_i;
			// reserved bit held at zero; software must write it so anyway
			if (wr_ctrl_b) ctrl_b_reg <= reg_wdata_i & 8'hDF;
			if (wr_ien) ien_reg <= reg_wdata_i & `TCR_I_MASK;
			temp_reg <= temp_next;
			rdata_reg <= reg_rd_i ? rdata_next : 8'h00;
		end
	end

	// word registers stay cpu writable even while stopped
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cnt_reg <= `TCR_RST_WORD;
			cmpa_reg <= `TCR_RST_WORD;
			cmpb_reg <= `TCR_RST_WORD;
			cap_reg <= `TCR_RST_WORD;
			dir_reg <= TCR_DIR_UP;
		end else begin
			cnt_reg <= cnt_next;
			dir_reg <= dir_next;
			if (wr_cmpa_l) cmpa_reg <= wr_word;
			if (wr_cmpb_l) cmpb_reg <= wr_word;
			if (wr_cap_l) cap_reg <= wr_word;
			else if (cap_event) cap_reg <= cnt_reg;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pre_reg <= 10'h000;
			ext_d_reg <= 1'b0;
			cap_d_reg <= 1'b0;
			block_reg <= 1'b0;
			mat_a_reg <= 1'b0;
			mat_b_reg <= 1'b0;
		end else begin
			pre_reg <= (csel == TCR_CS_STOP) ? 10'h000 : pre_reg + 10'h001;
			ext_d_reg <= external_count_pin_i;
			cap_d_reg <= cap_filt;
			// a counter write masks compares until the next timer clock has passed
			if (wr_cnt_l) block_reg <= 1'b1;
			else if (tick) block_reg <= 1'b0;
			if (tick) begin
				mat_a_reg <= eq_a;
				mat_b_reg <= eq_b;
			end else if (wr_cnt_l) begin
				mat_a_reg <= 1'b0;
				mat_b_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			flg_reg <= `TCR_RST_BYTE;
			wave_a_reg <= 1'b0;
			wave_b_reg <= 1'b0;
			irq_reg <= 4'h0;
		end else begin
			flg_reg <= flg_next;
			wave_a_reg <= wave_a_next;
			wave_b_reg <= wave_b_next;
			irq_reg <= irq_next;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign wave_out_a_o = wave_a_reg;
	assign wave_out_b_o = wave_b_reg;
	assign irq_o = irq_reg;
endmodule

// ===== tcr_timer16_props.sv
// tcr_timer16_props.sv: port-level assertions of the 16-bit timer
// assumes: bound into tcr_timer16; a read answers in the cycle after its strobe
`timescale 1ns/100ps
`include "tcr_defines.svh"
module tcr_props (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// system and outputs
	input wire logic global_irq_enable_i,
	input wire logic wave_out_a_o,
	input wire logic wave_out_b_o,
	input wire logic [3:0] irq_o
);
	// shadow of the enable bits, {cap,cmpb,cmpa,ovf}
	logic [3:0] ien_reg;
	wire logic rd_b = reg_rd_i && reg_addr_i == `TCR_OFS_CTRL_B;
	wire logic rd_c = reg_rd_i && reg_addr_i == `TCR_OFS_CTRL_C;
	wire logic rd_e = reg_rd_i && reg_addr_i == `TCR_OFS_IEN;
	wire logic rd_f = reg_rd_i && reg_addr_i == `TCR_OFS_IFLG;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i)
			ien_reg <= 4'h0;
		else if (reg_wr_i && reg_addr_i == `TCR_OFS_IEN)
			ien_reg <= {reg_wdata_i[5], reg_wdata_i[2:0]};
	end
	idle_read_zero_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	force_read_zero_a: assert property (rd_c |=> reg_rdata_o == 8'h00)
		else $error("force bits read back nonzero");
	ctrl_rsvd_zero_a: assert property (rd_b |=> !reg_rdata_o[5])
		else $error("reserved control bit reads one");
	flag_rsvd_zero_a: assert property (rd_f |=> (reg_rdata_o & ~`TCR_I_MASK) == 8'h00)
		else $error("unused flag bits read nonzero");
	ien_readback_a: assert property (rd_e |=> reg_rdata_o == {2'b00, $past(ien_reg[3]), 2'b00, $past(ien_reg[2:0])})
		else $error("enable register reads back wrong");
	irq_global_a: assert property (!global_irq_enable_i |=> irq_o == 4'h0)
		else $error("request while globally disabled");
	irq_needs_enable_a: assert property ((irq_o & ~$past(ien_reg)) == 4'h0)
		else $error("request without its enable bit");
	reset_quiet_a: assert property ($rose(resetn_i) |-> irq_o == 4'h0 && !wave_out_a_o && !wave_out_b_o)
		else $error("outputs not quiet after reset");
	cover property (rd_c);
	cover property ($rose(irq_o[1]));
	cover property ($rose(wave_out_b_o));
endmodule
bind tcr_timer16 tcr_props i_tcr_props (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.reg_rdata_o, .global_irq_enable_i, .wave_out_a_o, .wave_out_b_o, .irq_o);

// ===== testbench.sv
// testbench.sv: register-level test of the 16-bit timer
// assumes: design, package and checker compiled first
`timescale 1ns/100ps
module testbench;
	logic clk_sys_i = 0;
	logic resetn_i = 0;
	logic [7:0] a = 0;
	logic [7:0] d = 0;
	logic [7:0] q;
	logic wr = 0, rd = 0, cap = 0, cmp = 0, csel = 0, ext = 0, gie = 0;
	logic [3:0] ack = 0;
	logic [3:0] irq;
	logic wa, wb;
	logic [15:0] v;
	int fail_count = 0, n_tests = 0, cyc = 0, n;
	int dv[5] = '{1, 8, 64, 256, 1024};
	tcr_timer16 i_tcr_timer16 (.clk_sys_i, .resetn_i, .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr),
		.reg_rd_i(rd), .reg_rdata_o(q), .capture_input_pin_i(cap), .comparator_out_i(cmp),
		.capture_from_comparator_i(csel), .external_count_pin_i(ext), .global_irq_enable_i(gie),
		.irq_ack_i(ack), .wave_out_a_o(wa), .wave_out_b_o(wb), .irq_o(irq));
	initial forever #50 clk_sys_i = ~clk_sys_i;
	task close_out;
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard: the prescaler sweep alone needs about 14000 cycles
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			close_out;
		end
	end
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task tk(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	task wr8(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clk_sys_i);
		a <= ad;
		d <= dt;
		wr <= 1;
		@(posedge clk_sys_i);
		wr <= 0;
	endtask
	// data sampled just after the edge that ends the answer cycle's start
	task rd8(input logic [7:0] ad, output logic [15:0] r);
		@(posedge clk_sys_i);
		a <= ad;
		rd <= 1;
		@(posedge clk_sys_i);
		rd <= 0;
		#1 r = {8'h00, q};
	endtask
	// high byte first through the shared latch, low byte read first
	task w16(input logic [7:0] ad, input logic [15:0] val);
		wr8(ad + 8'h01, val[15:8]);
		wr8(ad, val[7:0]);
	endtask
	task r16(input logic [7:0] ad, output logic [15:0] r);
		logic [15:0] lo, hi;
		rd8(ad, lo);
		rd8(ad + 8'h01, hi);
		r = {hi[7:0], lo[7:0]};
	endtask
	task run(input logic [7:0] cs, input int k);
		wr8(8'h01, cs);
		tk(k);
		wr8(8'h01, 8'h00);
	endtask
	task drive(input logic p, input logic c);
		@(posedge clk_sys_i);
		cap <= p;
		cmp <= c;
		tk(8);
	endtask
	task flags(input logic [15:0] e);
		rd8(8'h0D, v);
		chk(v, e);
	endtask
	initial begin
		tk(6);
		resetn_i <= 1;
		for (int i = 0; i < 16; i++) begin
			rd8(i[7:0], v);
			chk(v, 16'h0000);
		end
		// stopped counter stays reachable; a lone high write touches only the latch
		w16(8'h04, 16'h1234);
		wr8(8'h05, 8'h77);
		r16(8'h04, v);
		chk(v, 16'h1234);
		w16(8'h08, 16'hA55A);
		r16(8'h08, v);
		chk(v, 16'hA55A);
		wr8(8'h01, 8'hE0);
		rd8(8'h01, v);
		chk(v, 16'h00C0);
		wr8(8'h01, 8'h00);
		gie <= 1;
		wr8(8'h0C, 8'h27);
		wr8(8'h00, 8'h70);
		wr8(8'h02, 8'hC0);
		tk(2);
		chk({14'h0, wa, wb}, 16'h0003);
		wr8(8'h02, 8'h80);
		tk(2);
		chk({15'h0, wa}, 16'h0000);
		flags(16'h0000);
		chk({12'h0, irq}, 16'h0000);
		rd8(8'h02, v);
		chk(v, 16'h0000);
		// a fast pwm mode ignores the force strobe
		wr8(8'h00, 8'h71);
		wr8(8'h01, 8'h08);
		wr8(8'h02, 8'h80);
		tk(2);
		chk({15'h0, wa}, 16'h0000);
		wr8(8'h00, 8'h00);
		w16(8'h04, 16'h0000);
		w16(8'h08, 16'h0005);
		w16(8'h0A, 16'h0007);
		run(8'h01, 20);
		flags(16'h0006);
		chk({12'h0, irq}, 16'h0006);
		@(posedge clk_sys_i) gie <= 0;
		tk(2);
		#1 chk({12'h0, irq}, 16'h0000);
		@(posedge clk_sys_i) gie <= 1;
		wr8(8'h0D, 8'h00);
		flags(16'h0006);
		wr8(8'h0D, 8'h02);
		flags(16'h0004);
		@(posedge clk_sys_i) ack <= 4'h4;
		@(posedge clk_sys_i) ack <= 4'h0;
		flags(16'h0000);
		// count written equal to channel a: only channel b may match
		w16(8'h04, 16'h0005);
		run(8'h01, 20);
		flags(16'h0004);
		wr8(8'h0D, 8'h27);
		w16(8'h04, 16'hFFFD);
		run(8'h01, 10);
		flags(16'h0007);
		// start latency of the prescaler allows one tick either way
		for (int i = 1; i < 6; i++) begin
			w16(8'h04, 16'h0000);
			run(i[7:0], 10 * dv[i - 1]);
			r16(8'h04, v);
			n = (10 * dv[i - 1] + 1) / dv[i - 1];
			chk({15'h0, v + 16'h0001 >= n[15:0] && v <= n[15:0] + 16'h0001}, 16'h0001);
		end
		for (int k = 0; k < 2; k++) begin
			w16(8'h04, 16'h0000);
			wr8(8'h01, 8'h06 + k[7:0]);
			repeat (5) begin
				@(posedge clk_sys_i) ext <= 1;
				tk(4);
				ext <= 0;
				tk(4);
			end
			wr8(8'h01, 8'h00);
			r16(8'h04, v);
			chk(v, 16'h0005);
		end
		wr8(8'h0D, 8'h27);
		w16(8'h04, 16'h0042);
		wr8(8'h01, 8'h40);
		drive(1, 0);
		r16(8'h06, v);
		chk(v, 16'h0042);
		flags(16'h0020);
		wr8(8'h0D, 8'h27);
		drive(0, 0);
		flags(16'h0000);
		wr8(8'h01, 8'h00);
		w16(8'h04, 16'h0055);
		drive(1, 0);
		drive(0, 0);
		r16(8'h06, v);
		chk(v, 16'h0055);
		@(posedge clk_sys_i) csel <= 1;
		wr8(8'h01, 8'h40);
		w16(8'h04, 16'h0066);
		drive(0, 1);
		r16(8'h06, v);
		chk(v, 16'h0066);
		@(posedge clk_sys_i) csel <= 0;
		// a two-cycle glitch must not pass the filter, a steady level must
		wr8(8'h01, 8'hC0);
		w16(8'h04, 16'h0077);
		wr8(8'h0D, 8'h27);
		@(posedge clk_sys_i) cap <= 1;
		tk(2);
		cap <= 0;
		tk(8);
		flags(16'h0000);
		drive(1, 1);
		r16(8'h06, v);
		chk(v, 16'h0077);
		wr8(8'h0D, 8'h27);
		wr8(8'h01, 8'h18);
		w16(8'h04, 16'h0088);
		drive(0, 1);
		drive(1, 1);
		r16(8'h06, v);
		chk(v, 16'h0077);
		flags(16'h0000);
		// clear-on-capture-top mode: wraps after 0x0077 and flags capture at top
		w16(8'h04, 16'h0070);
		run(8'h19, 10);
		flags(16'h0020);
		r16(8'h04, v);
		chk(v, 16'h0004);
		close_out;
	end
endmodule
